// >>> hw/nfc_ctrl.sv
// host controller driving a parallel nor flash over its pins
`timescale 1ns/1ns
`default_nettype none
`include "nfc_cfg.svh"
module nfc_ctrl #(
    parameter int unsigned TIMEOUT_CYC = `NFC_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic              I_CLK_SYS,
    input  wire logic              I_RST_N,
    // user request
    input  wire logic              I_REQ_VALID,
    input  wire nfc_pkg::nfc_req_s I_REQ,
    output logic                   O_REQ_READY,
    // user response
    output logic                   O_RSP_VALID,
    output logic [15:0]            O_RSP_DATA,
    output logic                   O_RSP_ERR,
    // flash pins
    input  wire logic [15:0]       I_DQ,
    output var nfc_pkg::nfc_pins_s O_PINS
);
    import nfc_pkg::*;

    // ------------------------------------------------------------
    // constants and types
    // ------------------------------------------------------------
    localparam logic [7:0] WE_CYC  = 8'(`NFC_WE_CYC);
    localparam logic [7:0] RD_CYC  = 8'(`NFC_ACC_CYC + `NFC_SYNC_CYC);
    localparam logic [31:0] TMO    = 32'(TIMEOUT_CYC);

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SETUP   = 3'b001,
        ST_WE_LOW  = 3'b011,
        ST_WE_HIGH = 3'b010,
        ST_GAP     = 3'b110,
        ST_RD_ACC  = 3'b111,
        ST_RD_SMP  = 3'b101,
        ST_RD_END  = 3'b100
    } nfc_state_e;

    // ------------------------------------------------------------
    // command sequence tables
    // ------------------------------------------------------------
    function automatic nfc_cyc_s seq_word(input nfc_cmd_e c,
                                          input logic [2:0] s,
                                          input nfc_req_s r);
        nfc_cyc_s    w;
        logic [7:0]  third;
        logic [7:0]  last;
        third = `NFC_DAT_SETUP;
        last  = `NFC_DAT_CHIP;
        case (c)
            NFC_CMD_PROG:       third = `NFC_DAT_PROG;
            NFC_CMD_ID_ENTRY:   third = `NFC_DAT_ID_IN;
            NFC_CMD_ID_EXIT:    third = `NFC_DAT_ID_OUT;
            default:            third = `NFC_DAT_SETUP;
        endcase
        case (c)
            NFC_CMD_MAIN_ERASE: last = `NFC_DAT_MAIN;
            NFC_CMD_LOCK:       last = `NFC_DAT_LOCK;
            default:            last = `NFC_DAT_CHIP;
        endcase
        // upper data byte driven zero, addresses kept below A12, except the program word and single exit
        case (s)
            3'h0: w = {`NFC_ADR_UNLK1, `NFC_HI_ZERO, `NFC_DAT_UNLK1};
            3'h1: w = {`NFC_ADR_UNLK2, `NFC_HI_ZERO, `NFC_DAT_UNLK2};
            3'h2: w = {`NFC_ADR_UNLK1, `NFC_HI_ZERO, third};
            3'h3: w = {`NFC_ADR_UNLK1, `NFC_HI_ZERO, `NFC_DAT_UNLK1};
            3'h4: w = {`NFC_ADR_UNLK2, `NFC_HI_ZERO, `NFC_DAT_UNLK2};
            default: w = {`NFC_ADR_UNLK1, `NFC_HI_ZERO, last};
        endcase
        if (c == NFC_CMD_PROG && s == `NFC_STEP_PROG) begin
            w = {r.addr, r.data};
        end
        if (c == NFC_CMD_ID_EXIT1) begin
            w = {r.addr, `NFC_HI_ZERO, `NFC_DAT_ID_OUT};
        end
        return w;
    endfunction

    function automatic logic [2:0] seq_len(input nfc_cmd_e c);
        case (c)
            NFC_CMD_PROG:       return `NFC_LEN_PROG;
            NFC_CMD_CHIP_ERASE: return `NFC_LEN_SIX;
            NFC_CMD_MAIN_ERASE: return `NFC_LEN_SIX;
            NFC_CMD_LOCK:       return `NFC_LEN_SIX;
            NFC_CMD_ID_ENTRY:   return `NFC_LEN_ID;
            NFC_CMD_ID_EXIT:    return `NFC_LEN_ID;
            NFC_CMD_ID_EXIT1:   return `NFC_LEN_ONE;
            default:            return `NFC_LEN_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    nfc_state_e  state;
    nfc_state_e  next_state;
    nfc_req_s    cur;
    nfc_req_s    next_cur;
    logic [2:0]  step;
    logic [2:0]  next_step;
    logic [7:0]  cnt;
    logic [7:0]  next_cnt;
    logic [31:0] tmo;
    logic [31:0] next_tmo;
    logic        have_prev;
    logic        next_have_prev;
    logic        prev_tgl;
    logic        next_prev_tgl;
    logic        more;
    logic        next_more;
    nfc_pins_s   next_pins;
    logic        next_ready;
    logic        next_rsp_valid;
    logic [15:0] next_rsp_data;
    logic        next_rsp_err;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic [15:0] dq_sync;
    wire logic        dq_stable;
    wire nfc_cyc_s    cyc_first = seq_word(I_REQ.cmd, 3'h0, I_REQ);
    wire logic [2:0]  step_inc  = 3'(step + 3'h1);
    wire nfc_cyc_s    cyc_next  = seq_word(cur.cmd, step_inc, cur);
    wire logic        steps_left = (step_inc < seq_len(cur.cmd));
    // only self-timed operations are polled
    wire logic        polled = (cur.cmd == NFC_CMD_PROG)
                            || (cur.cmd == NFC_CMD_CHIP_ERASE)
                            || (cur.cmd == NFC_CMD_MAIN_ERASE)
                            || (cur.cmd == NFC_CMD_LOCK);
    wire logic        tgl_same = have_prev
                            && (prev_tgl == dq_sync[`NFC_BIT_TGL]);
    wire logic        poll_ok  = (cur.cmd != NFC_CMD_PROG)
                            || (dq_sync[`NFC_BIT_POLL]
                                == cur.data[`NFC_BIT_POLL]);
    wire logic        op_done  = tgl_same && poll_ok;
    wire logic        timed_out = (tmo >= TMO);

    nfc_sync #(
        .W (16)
    ) u_dq_sync (
        .i_clk    (I_CLK_SYS),
        .i_rst_n  (I_RST_N),
        .i_data   (I_DQ),
        .o_data   (dq_sync),
        .o_stable (dq_stable)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_cur       = cur;
        next_step      = step;
        next_cnt       = cnt;
        next_tmo       = (state == ST_IDLE) ? 32'h0 : 32'(tmo + 32'h1);
        next_have_prev = have_prev;
        next_prev_tgl  = prev_tgl;
        next_more      = more;
        next_pins      = O_PINS;
        next_ready     = O_REQ_READY;
        next_rsp_valid = 1'b0;
        next_rsp_data  = O_RSP_DATA;
        next_rsp_err   = O_RSP_ERR;
        case (state)
            ST_IDLE: begin
                if (I_REQ_VALID && O_REQ_READY) begin
                    next_cur       = I_REQ;
                    next_ready     = 1'b0;
                    next_step      = 3'h0;
                    next_have_prev = 1'b0;
                    next_pins.chip_select_n = 1'b0;
                    if (I_REQ.cmd == NFC_CMD_READ) begin
                        next_pins.address_lines   = I_REQ.addr;
                        next_pins.output_enable_n = 1'b0;
                        next_pins.data_oe         = 1'b0;
                        next_cnt   = RD_CYC;
                        next_state = ST_RD_ACC;
                    end else begin
                        // address and data set up before WE falls
                        next_pins.address_lines = cyc_first.addr;
                        next_pins.data_lines    = cyc_first.data;
                        next_pins.data_oe       = 1'b1;
                        next_state = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                next_pins.write_enable_n = 1'b0;  // OE stays high
                next_cnt   = 8'(WE_CYC - 8'h1);
                next_state = ST_WE_LOW;
            end
            ST_WE_LOW: begin
                // pulse spans whole clocks, far above the noise filter
                if (cnt == 8'h0) begin
                    next_pins.write_enable_n = 1'b1;
                    next_state = ST_WE_HIGH;
                end else begin
                    next_cnt = 8'(cnt - 8'h1);
                end
            end
            ST_WE_HIGH: begin
                // data held one clock past the WE rise
                next_pins.chip_select_n = 1'b1;
                next_pins.data_oe       = 1'b0;
                next_state = ST_GAP;
            end
            ST_GAP: begin
                next_pins.chip_select_n = 1'b0;
                if (steps_left) begin
                    next_step = step_inc;
                    next_pins.address_lines = cyc_next.addr;
                    next_pins.data_lines    = cyc_next.data;
                    next_pins.data_oe       = 1'b1;
                    next_state = ST_SETUP;
                end else if (polled) begin
                    // program, erase and lock run on their own; host only watches
                    next_pins.address_lines   = cur.addr;
                    next_pins.output_enable_n = 1'b0;
                    next_cnt   = RD_CYC;
                    next_state = ST_RD_ACC;
                end else begin
                    next_pins.chip_select_n = 1'b1;
                    next_rsp_valid = 1'b1;
                    next_rsp_data  = 16'h0;
                    next_rsp_err   = 1'b0;
                    next_ready     = 1'b1;
                    next_state     = ST_IDLE;
                end
            end
            ST_RD_ACC: begin
                // waits access time plus synchroniser depth
                if (cnt == 8'h0) begin
                    next_state = ST_RD_SMP;
                end else begin
                    next_cnt = 8'(cnt - 8'h1);
                end
            end
            ST_RD_SMP: begin
                if (dq_stable || timed_out) begin
                    next_pins.chip_select_n   = 1'b1;
                    next_pins.output_enable_n = 1'b1;
                    next_state    = ST_RD_END;
                    next_more     = 1'b0;
                    next_rsp_data = dq_sync;
                    next_rsp_err  = 1'b0;
                    if (cur.cmd == NFC_CMD_READ) begin
                        next_rsp_valid = 1'b1;
                    end else if (op_done) begin
                        next_rsp_valid = 1'b1;
                    end else if (timed_out) begin
                        next_rsp_valid = 1'b1;
                        next_rsp_err   = 1'b1;
                    end else begin
                        next_have_prev = 1'b1;
                        next_prev_tgl  = dq_sync[`NFC_BIT_TGL];
                        next_more      = 1'b1;
                    end
                end
            end
            ST_RD_END: begin
                // one idle clock so each poll is a distinct read
                if (more) begin
                    next_pins.chip_select_n   = 1'b0;
                    next_pins.output_enable_n = 1'b0;
                    next_cnt   = RD_CYC;
                    next_state = ST_RD_ACC;
                end else begin
                    next_ready = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state       <= ST_IDLE;
            cur         <= '0;
            step        <= 3'h0;
            cnt         <= 8'h0;
            tmo         <= 32'h0;
            have_prev   <= 1'b0;
            prev_tgl    <= 1'b0;
            more        <= 1'b0;
            O_PINS      <= {16'h0, 16'h0, 1'b0, 1'b1, 1'b1, 1'b1};
            O_REQ_READY <= 1'b0;
            O_RSP_VALID <= 1'b0;
            O_RSP_DATA  <= 16'h0;
            O_RSP_ERR   <= 1'b0;
        end else begin
            state       <= next_state;
            cur         <= next_cur;
            step        <= next_step;
            cnt         <= next_cnt;
            tmo         <= next_tmo;
            have_prev   <= next_have_prev;
            prev_tgl    <= next_prev_tgl;
            more        <= next_more;
            O_PINS      <= next_pins;
            O_REQ_READY <= (state == ST_IDLE && !O_REQ_READY) ? 1'b1
                         : next_ready;
            O_RSP_VALID <= next_rsp_valid;
            O_RSP_DATA  <= next_rsp_data;
            O_RSP_ERR   <= next_rsp_err;
        end
    end
endmodule
`default_nettype wire

// >>> hw/nfc_cfg.svh
// constants for the parallel nor flash host controller
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH

// ------------------------------------------------------------
// command addresses and bytes
// ------------------------------------------------------------
`define NFC_ADR_UNLK1   16'h0555
`define NFC_ADR_UNLK2   16'h0AAA
`define NFC_DAT_UNLK1   8'hAA
`define NFC_DAT_UNLK2   8'h55
`define NFC_DAT_SETUP   8'h80
`define NFC_DAT_PROG    8'hA0
`define NFC_DAT_ID_IN   8'h90
`define NFC_DAT_ID_OUT  8'hF0
`define NFC_DAT_CHIP    8'h10
`define NFC_DAT_MAIN    8'h30
`define NFC_DAT_LOCK    8'h40
`define NFC_HI_ZERO     8'h00
`define NFC_LOCK_ADDR   16'h0002

// ------------------------------------------------------------
// bit positions and sequence lengths
// ------------------------------------------------------------
`define NFC_BIT_POLL    7
`define NFC_BIT_TGL     6
`define NFC_LEN_PROG    3'h4
`define NFC_LEN_SIX     3'h6
`define NFC_LEN_ID      3'h3
`define NFC_LEN_ONE     3'h1
`define NFC_LEN_NONE    3'h0
`define NFC_STEP_PROG   3'h3

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define NFC_CLK_NS      40
`define NFC_WE_PULSE_NS 50
`define NFC_ACCESS_NS   45
`define NFC_ERASE_US    1500000
`define NFC_WE_CYC      ((`NFC_WE_PULSE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_ACC_CYC     ((`NFC_ACCESS_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_SYNC_CYC    3
`define NFC_TIMEOUT_CYC ((`NFC_ERASE_US * 1000) / `NFC_CLK_NS)

`endif

// >>> hw/nfc_pkg.sv
// types for the parallel nor flash host controller
package nfc_pkg;

    typedef enum logic [2:0] {
        NFC_CMD_READ       = 3'h0,
        NFC_CMD_PROG       = 3'h1,
        NFC_CMD_CHIP_ERASE = 3'h2,
        NFC_CMD_MAIN_ERASE = 3'h3,
        NFC_CMD_LOCK       = 3'h4,
        NFC_CMD_ID_ENTRY   = 3'h5,
        NFC_CMD_ID_EXIT    = 3'h6,
        NFC_CMD_ID_EXIT1   = 3'h7
    } nfc_cmd_e;

    typedef struct packed {
        nfc_cmd_e    cmd;
        logic [15:0] addr;
        logic [15:0] data;
    } nfc_req_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } nfc_cyc_s;

    typedef struct packed {
        logic [15:0] address_lines;
        logic [15:0] data_lines;
        logic        data_oe;
        logic        chip_select_n;
        logic        output_enable_n;
        logic        write_enable_n;
    } nfc_pins_s;

endpackage

// >>> hw/nfc_sync.sv
// three-stage synchroniser with agreement flag
`timescale 1ns/1ns
`default_nettype none
module nfc_sync #(
    parameter int W = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_data,
    output logic      [W-1:0] o_data,
    output logic              o_stable
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ff1 <= '0;
            ff2 <= '0;
            ff3 <= '0;
        end else begin
            ff1 <= i_data;
            ff2 <= ff1;
            ff3 <= ff2;
        end
    end

    // ff1 feeds only ff2; agreement of the later two marks a settled word
    assign o_data   = ff3;
    assign o_stable = (ff2 == ff3);
endmodule
`default_nettype wire

// >>> sim/nfc_flash_mdl.sv
// behavioural nor flash device on the host pins
`timescale 1ns/1ns
`default_nettype none
module nfc_flash_mdl #(
    parameter int          PROG_NS  = 2000,
    parameter int          ERASE_NS = 6000,
    // arbitrary identity values
    parameter logic [15:0] MFR_CODE = 16'h00A5,
    parameter logic [15:0] DEV_CODE = 16'h005A
) (
    // host pins
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_din,
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    // read drive
    output logic      [15:0] o_q,
    output logic             o_q_oe
);
    logic [15:0] mem [0:65535];
    logic [15:0] lat_a;
    logic [15:0] last_d;
    logic [2:0]  step;
    logic        busy;
    logic        tgl;
    logic        locked;
    logic        id_mode;
    time         t_fall;
    wire         wr_n   = i_ce_n | i_we_n;
    wire         rd_n   = i_ce_n | i_oe_n | ~i_we_n;
    wire         lo_ok  = !locked || lat_a >= 16'h2000;
    wire         u1     = lat_a[10:0] == 11'h555;
    wire         u2     = lat_a[10:0] == 11'h2AA;
    wire  [15:0] poll_q = {last_d[15:8], ~last_d[7], tgl, last_d[5:0]};

    assign o_q_oe = !rd_n;
    assign o_q = busy ? poll_q
        : !id_mode ? mem[i_addr]
        : i_addr == 16'h0002 ? {15'h0000, locked}
        : i_addr[0] ? DEV_CODE : MFR_CODE;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 16'hFFFF;
        end
        {lat_a, last_d, step, busy, tgl, locked, id_mode} = '0;
        t_fall = 0;
    end

    task automatic erase(input logic [15:0] lo);
        for (int i = 0; i < 65536; i++) begin
            if (i >= lo) mem[i] = 16'hFFFF;
        end
        last_d = 16'hFFFF;
        busy = 1'b1;
        busy <= #ERASE_NS 1'b0;
    endtask

    // any mismatched cycle falls back to read
    task automatic cmd(input logic [15:0] d);
        logic [7:0] b;
        b = d[7:0];
        case (step)
            3'h0: begin
                if (b == 8'hF0) id_mode = 1'b0;
                step = (u1 && b == 8'hAA) ? 3'h1 : 3'h0;
            end
            3'h1: step = (u2 && b == 8'h55) ? 3'h2 : 3'h0;
            3'h2: begin
                if (u1 && b == 8'h90) id_mode = 1'b1;
                if (u1 && b == 8'hF0) id_mode = 1'b0;
                step = !u1 ? 3'h0 : (b == 8'hA0) ? 3'h3
                     : (b == 8'h80) ? 3'h4 : 3'h0;
            end
            3'h3: begin
                step = 3'h0;
                last_d = d;
                if (lo_ok) begin
                    mem[lat_a] = mem[lat_a] & d;
                    busy = 1'b1;
                    busy <= #PROG_NS 1'b0;
                end
            end
            3'h4: step = (u1 && b == 8'hAA) ? 3'h5 : 3'h0;
            3'h5: step = (u2 && b == 8'h55) ? 3'h6 : 3'h0;
            default: begin
                step = 3'h0;
                if (u1 && b == 8'h10) erase(locked ? 16'h2000 : 16'h0);
                if (u1 && b == 8'h30) erase(16'h2000);
                if (u1 && b == 8'h40) locked = 1'b1;
            end
        endcase
    endtask

    always @(negedge wr_n) begin
        lat_a = i_addr;
        t_fall = $time;
    end
    always @(negedge rd_n) begin
        if (busy) tgl = ~tgl;
    end
    // glitches and writes with oe low are dropped
    always @(posedge wr_n) begin
        if (i_oe_n && !busy && $time - t_fall >= 15) cmd(i_din);
    end
endmodule
`default_nettype wire

// >>> sim/nfc_ctrl_chk.sv
// pin and port assertions for the flash host controller
`timescale 1ns/1ns
`default_nettype none
module nfc_ctrl_chk
    import nfc_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = 200
) (
    // clock and reset
    input wire logic               I_CLK_SYS,
    input wire logic               I_RST_N,
    // user side
    input wire logic               I_REQ_VALID,
    input wire nfc_pkg::nfc_req_s  I_REQ,
    input wire logic               O_REQ_READY,
    input wire logic               O_RSP_VALID,
    input wire logic [15:0]        O_RSP_DATA,
    input wire logic               O_RSP_ERR,
    // flash pins
    input wire logic [15:0]        I_DQ,
    input wire nfc_pkg::nfc_pins_s O_PINS
);
    nfc_cmd_e    cmd_q;
    logic [15:0] addr_q;
    logic [15:0] data_q;
    logic [2:0]  n_we;
    wire         we_n  = O_PINS.write_enable_n;
    wire  [7:0]  cbyte = O_PINS.data_lines[7:0];
    wire         at_1  = O_PINS.address_lines == 16'h0555;
    wire         at_2  = O_PINS.address_lines[10:0] == 11'h2AA;
    wire         six   = cmd_q inside {NFC_CMD_CHIP_ERASE,
                                       NFC_CMD_MAIN_ERASE, NFC_CMD_LOCK};
    wire  [7:0]  byte3 = cmd_q == NFC_CMD_PROG ? 8'hA0
                       : cmd_q == NFC_CMD_ID_ENTRY ? 8'h90
                       : cmd_q == NFC_CMD_ID_EXIT ? 8'hF0 : 8'h80;
    wire  [7:0]  byte6 = cmd_q == NFC_CMD_CHIP_ERASE ? 8'h10
                       : cmd_q == NFC_CMD_MAIN_ERASE ? 8'h30 : 8'h40;
    wire  [2:0]  n_exp = cmd_q == NFC_CMD_READ ? 3'h0
                       : cmd_q == NFC_CMD_PROG ? 3'h4 : six ? 3'h6
                       : cmd_q == NFC_CMD_ID_EXIT1 ? 3'h1 : 3'h3;

    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RST_N);

    sequence s_take;
        I_REQ_VALID && O_REQ_READY;
    endsequence
    sequence s_we_fall;
        $fell(we_n);
    endsequence

    // write cycles counted per request, saturating
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cmd_q  <= NFC_CMD_READ;
            addr_q <= 16'h0000;
            data_q <= 16'h0000;
            n_we   <= 3'h0;
        end else if (I_REQ_VALID && O_REQ_READY) begin
            cmd_q  <= I_REQ.cmd;
            addr_q <= I_REQ.addr;
            data_q <= I_REQ.data;
            n_we   <= 3'h0;
        end else if ($fell(we_n) && n_we != 3'h7) begin
            n_we   <= n_we + 3'h1;
        end
    end

    oe_read_a: assert property (
        !O_PINS.output_enable_n |-> !O_PINS.chip_select_n && we_n
            && !O_PINS.data_oe) else $error("oe low outside a read");
    we_inhibit_a: assert property (
        !we_n |-> !O_PINS.chip_select_n && O_PINS.output_enable_n
            && O_PINS.data_oe) else $error("bad write strobe");
    we_width_a: assert property (
        s_we_fall |=> !we_n ##1 we_n) else $error("we low not 2 clocks");
    we_hold_a: assert property (
        $rose(we_n) |-> !O_PINS.chip_select_n && O_PINS.data_oe
            && $stable(O_PINS.data_lines)
            && $stable(O_PINS.address_lines)) else $error("data not held");
    unlock_one_a: assert property (
        s_we_fall ##0 (n_we == 3'h0 && cmd_q != NFC_CMD_ID_EXIT1
            || n_we == 3'h3 && six) |-> at_1 && O_PINS.data_lines == 16'h00AA)
        else $error("bad first unlock cycle");
    unlock_two_a: assert property (
        s_we_fall ##0 (n_we == 3'h1 || n_we == 3'h4 && six)
            |-> at_2 && cbyte == 8'h55) else $error("bad second unlock");
    third_byte_a: assert property (
        s_we_fall ##0 n_we == 3'h2 |-> at_1 && cbyte == byte3)
        else $error("bad third command cycle");
    prog_word_a: assert property (
        s_we_fall ##0 (n_we == 3'h3 && cmd_q == NFC_CMD_PROG)
            |-> O_PINS.address_lines == addr_q && O_PINS.data_lines == data_q)
        else $error("bad program word cycle");
    sixth_byte_a: assert property (
        s_we_fall ##0 (n_we == 3'h5 && six) |-> at_1 && cbyte == byte6)
        else $error("bad sixth command cycle");
    exit_one_a: assert property (
        s_we_fall ##0 cmd_q == NFC_CMD_ID_EXIT1 |-> n_we == 3'h0
            && cbyte == 8'hF0) else $error("bad single exit write");
    cycle_count_a: assert property (
        O_RSP_VALID |-> n_we == n_exp) else $error("wrong write cycles");
    read_time_a: assert property (
        s_take ##0 I_REQ.cmd == NFC_CMD_READ |-> ##[7:9] O_RSP_VALID)
        else $error("read answer late");
endmodule
bind nfc_ctrl nfc_ctrl_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (
    .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_REQ_VALID(I_REQ_VALID),
    .I_REQ(I_REQ), .O_REQ_READY(O_REQ_READY), .O_RSP_VALID(O_RSP_VALID),
    .O_RSP_DATA(O_RSP_DATA), .O_RSP_ERR(O_RSP_ERR), .I_DQ(I_DQ),
    .O_PINS(O_PINS));
`default_nettype wire

// >>> sim/nfc_ctrl_tb_top.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ns
`default_nettype none
module nfc_ctrl_tb_top;
    import nfc_pkg::*;
    localparam logic [15:0] MFR = 16'h00A5; // arbitrary value
    logic        clk;
    logic        rst_n;
    logic        req_valid;
    nfc_req_s    req;
    logic        req_ready;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        rsp_err;
    nfc_pins_s   pins;
    logic [15:0] dev_q;
    logic        dev_oe;
    logic [15:0] float_v;
    logic [15:0] got;
    wire  [15:0] dq;
    int          n_mismatch;
    int          n_checks;
    int          n_cyc;

    // a released bus shows a pattern that flips every clock
    assign dq = pins.data_oe ? pins.data_lines : dev_oe ? dev_q : float_v;
    always @(posedge clk) float_v <= ~dq;
    always #20 clk = ~clk;

    nfc_ctrl #(.TIMEOUT_CYC(2000)) dut_u (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_REQ_VALID(req_valid),
        .I_REQ(req), .O_REQ_READY(req_ready), .O_RSP_VALID(rsp_valid),
        .O_RSP_DATA(rsp_data), .O_RSP_ERR(rsp_err), .I_DQ(dq),
        .O_PINS(pins));
    nfc_flash_mdl #(.PROG_NS(2000), .ERASE_NS(6000), .MFR_CODE(MFR)) mdl_u (
        .i_addr(pins.address_lines), .i_din(dq),
        .i_ce_n(pins.chip_select_n), .i_oe_n(pins.output_enable_n),
        .i_we_n(pins.write_enable_n), .o_q(dev_q), .o_q_oe(dev_oe));

    task automatic check(input string nm, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // the bounded waits keep a stuck handshake from hanging the run
    task automatic do_req(input nfc_cmd_e c, input logic [15:0] a, d);
        int k;
        k = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        req_valid = 1'b1;
        req = '{cmd: c, addr: a, data: d};
        @(negedge clk);
        req_valid = 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        check("rsp_valid", {15'h0, rsp_valid}, 16'h0001);
        check("rsp_err", {15'h0, rsp_err}, 16'h0000);
        got = rsp_data;
    endtask
    task automatic rd(input logic [15:0] a, exp);
        do_req(NFC_CMD_READ, a, 16'h0000);
        check("read word", got, exp);
    endtask

    always @(posedge clk) begin
        n_cyc <= n_cyc + 1;
        if (n_cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        {clk, rst_n, req_valid, n_mismatch, n_checks, n_cyc} = '0;
        req = '0;
        float_v = 16'h0000;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        rd(16'h1234, 16'hFFFF);
        do_req(NFC_CMD_PROG, 16'h1234, 16'hA5C3);
        check("poll word", got, 16'hA5C3);
        rd(16'h1234, 16'hA5C3);
        do_req(NFC_CMD_PROG, 16'h1234, 16'hFFF0);
        rd(16'h1234, 16'hA5C0);
        do_req(NFC_CMD_PROG, 16'h0010, 16'h1234);
        do_req(NFC_CMD_CHIP_ERASE, 16'h0010, 16'h0000);
        rd(16'h0010, 16'hFFFF);
        rd(16'h1234, 16'hFFFF);
        do_req(NFC_CMD_PROG, 16'h0010, 16'h1234);
        do_req(NFC_CMD_PROG, 16'h2000, 16'h0000);
        do_req(NFC_CMD_MAIN_ERASE, 16'h2000, 16'h0000);
        rd(16'h0010, 16'h1234);
        rd(16'h2000, 16'hFFFF);
        do_req(NFC_CMD_ID_ENTRY, 16'h0000, 16'h0000);
        check("id rsp word", got, 16'h0000);
        rd(16'h0002, 16'h0000);
        rd(16'h0000, MFR);
        do_req(NFC_CMD_ID_EXIT, 16'h0000, 16'h0000);
        rd(16'h0002, 16'hFFFF);
        do_req(NFC_CMD_LOCK, 16'h0010, 16'h0000);
        do_req(NFC_CMD_ID_ENTRY, 16'h0000, 16'h0000);
        rd(16'h0002, 16'h0001);
        do_req(NFC_CMD_ID_EXIT1, 16'h0000, 16'h0000);
        rd(16'h0002, 16'hFFFF);
        do_req(NFC_CMD_PROG, 16'h0010, 16'h0000);
        rd(16'h0010, 16'h1234);
        do_req(NFC_CMD_PROG, 16'h2000, 16'h0F0F);
        rd(16'h2000, 16'h0F0F);
        do_req(NFC_CMD_CHIP_ERASE, 16'h0010, 16'h0000);
        rd(16'h0010, 16'h1234);
        rd(16'h2000, 16'hFFFF);
        give_verdict();
    end
endmodule
`default_nettype wire
